// File: rsc_pkg.sv
// constants and decode tables for the reset strap clock ratio selection
// How it works
// [RULE_01] four platform straps decode to 3,4,5,6,8,9,10 or 12 to one
// [RULE_02] board pulls every platform strap; no default ratio exists
// [RULE_03] three core straps decode to core to platform ratio in halves
// [RULE_04] memory field decodes 3..12 to one, 110 reserved, 111 synchronous
// [RULE_05] synchronous memory buses run at half the platform clock
// [RULE_06] data rate equals platform clock when synchronous, else PLL output
// [RULE_07] board supplies memory reference clock only for asynchronous mode
// [RULE_08] memory divide setting halves the memory bus clock
// [RULE_09] software sets memory divide before memory controller init starts
// [RULE_10] PCI clock from system reference when synchronous, else PCI pin
// [RULE_11] board gives separate PCI clock when reference is out of range
// [RULE_12] io port straps may power down the first serial lane block
// [RULE_13] straps captured once after reset release, held until next reset
// [RULE_14] reserved code in any sampled ratio field flags configuration error
package rsc_pkg;
   // platform ratio strap codes
   localparam logic [3:0] PLAT_CODE_3  = 4'h3;
   localparam logic [3:0] PLAT_CODE_4  = 4'h4;
   localparam logic [3:0] PLAT_CODE_5  = 4'h5;
   localparam logic [3:0] PLAT_CODE_6  = 4'h6;
   localparam logic [3:0] PLAT_CODE_8  = 4'h8;
   localparam logic [3:0] PLAT_CODE_9  = 4'h9;
   localparam logic [3:0] PLAT_CODE_10 = 4'ha;
   localparam logic [3:0] PLAT_CODE_12 = 4'hc;
   // core ratio strap codes, ratio given in halves
   localparam logic [2:0] CORE_CODE_RSVD = 3'h2;
   // memory ratio field codes
   localparam logic [2:0] MEM_CODE_RSVD  = 3'h6;
   localparam logic [2:0] MEM_CODE_SYNC  = 3'h7;
   // memory bus divisor relative to the data rate source
   localparam logic [2:0] MEM_BUS_DIV_DEFAULT = 3'h2;
   localparam logic [2:0] MEM_BUS_DIV_HALVED  = 3'h4;
   // permitted PCI input clock range
   localparam int PCI_MIN_MHZ = 33;
   localparam int PCI_MAX_MHZ = 66;
   // values after reset
   localparam logic [3:0] RATIO_RST   = 4'h0;
   localparam logic [2:0] BUS_DIV_RST = 3'h0;

   // platform ratio as multiplier, zero for reserved
   function automatic logic [3:0] rsc_platform_dec(input logic [3:0] c);
      case (c)
         PLAT_CODE_3, PLAT_CODE_4, PLAT_CODE_5, PLAT_CODE_6,
         PLAT_CODE_8, PLAT_CODE_9, PLAT_CODE_10, PLAT_CODE_12:
            rsc_platform_dec = c;
         default: rsc_platform_dec = 4'h0;
      endcase
   endfunction

   // core ratio in halves, zero for reserved
   function automatic logic [3:0] rsc_core_dec(input logic [2:0] c);
      case (c)
         3'h0:    rsc_core_dec = 4'h8;
         3'h1:    rsc_core_dec = 4'h9;
         3'h3:    rsc_core_dec = 4'h3;
         3'h4:    rsc_core_dec = 4'h4;
         3'h5:    rsc_core_dec = 4'h5;
         3'h6:    rsc_core_dec = 4'h6;
         3'h7:    rsc_core_dec = 4'h7;
         default: rsc_core_dec = 4'h0;
      endcase
   endfunction

   // memory PLL multiplier, zero for reserved or synchronous
   function automatic logic [3:0] rsc_mem_dec(input logic [2:0] c);
      case (c)
         3'h0:    rsc_mem_dec = 4'h3;
         3'h1:    rsc_mem_dec = 4'h4;
         3'h2:    rsc_mem_dec = 4'h6;
         3'h3:    rsc_mem_dec = 4'h8;
         3'h4:    rsc_mem_dec = 4'ha;
         3'h5:    rsc_mem_dec = 4'hc;
         default: rsc_mem_dec = 4'h0;
      endcase
   endfunction
endpackage

// File: rsc_clock_ratio_select.sv
// strap capture and clock ratio selection logic
`timescale 1ns/1ps
`default_nettype none
module rsc_clock_ratio_select #(
   parameter int         SYS_REF_MHZ   = 40,
   parameter logic [2:0] LANE1_PD_CODE = 3'h7
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [3:0] platform_ratio_strap,
   input  wire logic       local_bus_control_strap,
   input  wire logic       address_latch_strap,
   input  wire logic       general_purpose_line_two_strap,
   input  wire logic [2:0] memory_ratio_strap,
   input  wire logic [2:0] io_port_config_strap,
   input  wire logic       pci_async_strap,
   input  wire logic       memory_clock_divide_setting,
   input  wire logic       memory_init_start,
   output logic      [3:0] platform_ratio_r,
   output logic      [3:0] core_ratio_halves_r,
   output logic      [3:0] mem_pll_ratio_r,
   output logic            mem_sync_mode_r,
   output logic            mem_data_from_pll_r,
   output logic      [2:0] mem_bus_div_r,
   output logic            pci_clk_from_alt_r,
   output logic            lane1_power_down_r,
   output logic            config_error_r,
   output logic            ratios_valid_r
);
   import rsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // captured straps
   logic       cap_done_r;
   logic [3:0] cap_plat_r;
   logic [2:0] cap_core_r;
   logic [2:0] cap_mem_r;
   logic [2:0] cap_io_r;
   logic       cap_pci_r;
   logic       div_lock_r;
   logic       div_held_r;
   logic       div_eff;
   logic       pci_in_range;

   assign pci_in_range = (SYS_REF_MHZ >= PCI_MIN_MHZ) &&
                         (SYS_REF_MHZ <= PCI_MAX_MHZ);
   // divide setting is frozen once memory init begins
   assign div_eff = div_lock_r ? div_held_r : memory_clock_divide_setting;

   // single capture on the first clock after reset release
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cap_done_r <= 1'b0;
         cap_plat_r <= 4'h0;
         cap_core_r <= 3'h0;
         cap_mem_r  <= 3'h0;
         cap_io_r   <= 3'h0;
         cap_pci_r  <= 1'b0;
      end else if (!cap_done_r) begin
         cap_done_r <= 1'b1;                               // [RULE_13]
         cap_plat_r <= platform_ratio_strap;               // [RULE_13]
         cap_core_r <= {local_bus_control_strap, address_latch_strap,
                        general_purpose_line_two_strap};
         cap_mem_r  <= memory_ratio_strap;
         cap_io_r   <= io_port_config_strap;
         cap_pci_r  <= pci_async_strap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ratio decode, stable because captured straps never change
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         platform_ratio_r    <= RATIO_RST;
         core_ratio_halves_r <= RATIO_RST;
         mem_pll_ratio_r     <= RATIO_RST;
         mem_sync_mode_r     <= 1'b0;
         mem_data_from_pll_r <= 1'b0;
         ratios_valid_r      <= 1'b0;
      end else if (cap_done_r) begin
         platform_ratio_r    <= rsc_platform_dec(cap_plat_r);  // [RULE_01]
         core_ratio_halves_r <= rsc_core_dec(cap_core_r);      // [RULE_03]
         mem_pll_ratio_r     <= rsc_mem_dec(cap_mem_r);        // [RULE_04]
         mem_sync_mode_r     <= (cap_mem_r == MEM_CODE_SYNC);  // [RULE_04]
         // data rate source: platform clock or memory PLL
         mem_data_from_pll_r <= (cap_mem_r != MEM_CODE_SYNC);  // [RULE_06]
         ratios_valid_r      <= 1'b1;
      end
   end

   // error on any reserved strap code, or sync PCI with bad reference
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         config_error_r <= 1'b0;
      end else if (cap_done_r) begin
         config_error_r <= (rsc_platform_dec(cap_plat_r) == 4'h0) ||
                           (cap_core_r == CORE_CODE_RSVD) ||
                           (cap_mem_r == MEM_CODE_RSVD) ||
                           (!cap_pci_r && !pci_in_range); // [RULE_14]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pci clock source and serial lane power down
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pci_clk_from_alt_r <= 1'b0;
         lane1_power_down_r <= 1'b0;
      end else if (cap_done_r) begin
         pci_clk_from_alt_r <= cap_pci_r;                        // [RULE_10]
         lane1_power_down_r <= (cap_io_r == LANE1_PD_CODE);      // [RULE_12]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // memory divide latch: held from the start of memory init
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_lock_r <= 1'b0;
         div_held_r <= 1'b0;
      end else if (!div_lock_r && memory_init_start && cap_done_r) begin
         div_lock_r <= 1'b1;                                     // [RULE_09]
         div_held_r <= memory_clock_divide_setting;
      end
   end

   // memory bus clock divisor relative to the data rate source
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_bus_div_r <= BUS_DIV_RST;
      end else if (cap_done_r) begin
         mem_bus_div_r <= div_eff ? MEM_BUS_DIV_HALVED           // [RULE_08]
                                  : MEM_BUS_DIV_DEFAULT;         // [RULE_05]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_release;
      rst ##1 !rst;
   endsequence

   sequence s_valid_two;
      ratios_valid_r ##1 ratios_valid_r;
   endsequence

   property p_capture_timing;
      @(posedge sys_clk) s_release |-> !ratios_valid_r ##2 ratios_valid_r;
   endproperty
   a_capture_timing: assert property (p_capture_timing) // [RULE_13]
      else $error("ratios not valid two cycles after reset release");

   property p_hold;
      @(posedge sys_clk) disable iff (rst)
      s_valid_two |-> $stable(platform_ratio_r) && $stable(core_ratio_halves_r)
                      && $stable(mem_pll_ratio_r) && $stable(config_error_r);
   endproperty
   a_hold: assert property (p_hold) // [RULE_13]
      else $error("decoded ratio changed after capture");

   property p_platform;
      @(posedge sys_clk) disable iff (rst)
      ratios_valid_r |-> platform_ratio_r == rsc_platform_dec(cap_plat_r);
   endproperty
   a_platform: assert property (p_platform) // [RULE_01]
      else $error("platform ratio does not match strap");

   property p_core;
      @(posedge sys_clk) disable iff (rst)
      ratios_valid_r |-> core_ratio_halves_r == rsc_core_dec(cap_core_r);
   endproperty
   a_core: assert property (p_core) // [RULE_03]
      else $error("core ratio does not match strap");

   property p_mem;
      @(posedge sys_clk) disable iff (rst)
      ratios_valid_r |-> mem_pll_ratio_r == rsc_mem_dec(cap_mem_r) &&
                         mem_sync_mode_r == (cap_mem_r == MEM_CODE_SYNC);
   endproperty
   a_mem: assert property (p_mem) // [RULE_04]
      else $error("memory ratio or sync mode does not match field");

   property p_data_src;
      @(posedge sys_clk) disable iff (rst)
      ratios_valid_r |-> mem_data_from_pll_r != mem_sync_mode_r;
   endproperty
   a_data_src: assert property (p_data_src) // [RULE_06]
      else $error("memory data rate source wrong for mode");

   property p_bus_div;
      @(posedge sys_clk) disable iff (rst)
      ratios_valid_r |=> mem_bus_div_r == ($past(div_eff) ?
                         MEM_BUS_DIV_HALVED : MEM_BUS_DIV_DEFAULT);
   endproperty
   a_bus_div: assert property (p_bus_div) // [RULE_08]
      else $error("memory bus divisor does not follow divide setting");

   property p_div_frozen;
      @(posedge sys_clk) disable iff (rst)
      div_lock_r ##1 ratios_valid_r |-> $stable(mem_bus_div_r);
   endproperty
   a_div_frozen: assert property (p_div_frozen) // [RULE_09]
      else $error("memory divisor changed after memory init began");

   property p_pci;
      @(posedge sys_clk) disable iff (rst)
      ratios_valid_r |-> pci_clk_from_alt_r == cap_pci_r;
   endproperty
   a_pci: assert property (p_pci) // [RULE_10]
      else $error("pci clock source does not match strap");

   property p_lane;
      @(posedge sys_clk) disable iff (rst)
      ratios_valid_r |-> lane1_power_down_r == (cap_io_r == LANE1_PD_CODE);
   endproperty
   a_lane: assert property (p_lane) // [RULE_12]
      else $error("lane power down does not match io straps");

   // error flag must match the decoded outputs in both directions
   property p_error;
      @(posedge sys_clk) disable iff (rst)
      ratios_valid_r |-> config_error_r == ((platform_ratio_r == 4'h0) ||
         (core_ratio_halves_r == 4'h0) ||
         (mem_pll_ratio_r == 4'h0 && !mem_sync_mode_r) ||
         (!pci_clk_from_alt_r && !pci_in_range));
   endproperty
   a_error: assert property (p_error) // [RULE_14]
      else $error("config error does not match reserved codes");
endmodule
`default_nettype wire

// File: rsc_board_straps.sv
// board strap and reference clock model facing the ratio selection block
`timescale 1ns/1ps
`default_nettype none
module rsc_board_straps (
   input  wire logic [13:0] cfg,
   output logic      [3:0]  platform_ratio_strap,
   output logic             local_bus_control_strap,
   output logic             address_latch_strap,
   output logic             general_purpose_line_two_strap,
   output logic      [2:0]  memory_ratio_strap,
   output logic      [2:0]  io_port_config_strap,
   output logic             pci_async_strap
);
   logic mem_ref_clk = 1'b0;
   // every strap is pulled to a definite level, none left floating
   assign platform_ratio_strap = cfg[13:10];
   assign {local_bus_control_strap, address_latch_strap,
           general_purpose_line_two_strap} = cfg[9:7];
   assign memory_ratio_strap = cfg[6:4];
   assign io_port_config_strap = cfg[3:1];
   // separate pci clock chosen by strap; reference stays in pci range
   assign pci_async_strap = cfg[0];
   // memory reference clock runs only in asynchronous mode
   always #10 mem_ref_clk = (memory_ratio_strap != 3'h7) & ~mem_ref_clk;
endmodule
`default_nettype wire

// File: reset_strap_clock_ratio_select_test.sv
// self-checking bench for strap capture and clock ratio selection
`timescale 1ns/1ps
`default_nettype none
module reset_strap_clock_ratio_select_test;
   import rsc_pkg::*;
   localparam int REF_MHZ = 40;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [13:0] cfg = 14'h0;
   logic        div_set = 1'b0;
   logic        init_go = 1'b0;
   int          err_total = 0;
   int          n_compared = 0;
   int          cyc = 0;
   wire logic [3:0] plat_s;
   wire logic       lbc_s, ale_s, gpl_s, pci_s;
   wire logic [2:0] mem_s, io_s;
   logic [3:0] plat_o, core_o, mpll_o;
   logic [2:0] div_o;
   logic       sync_o, pll_o, alt_o, pd_o, err_o, val_o;
   logic [3:0] ct [8] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
   logic [3:0] mt [8] = '{4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'h0, 4'h0};

   rsc_board_straps board (.cfg(cfg), .platform_ratio_strap(plat_s),
      .local_bus_control_strap(lbc_s), .address_latch_strap(ale_s),
      .general_purpose_line_two_strap(gpl_s), .memory_ratio_strap(mem_s),
      .io_port_config_strap(io_s), .pci_async_strap(pci_s));
   rsc_clock_ratio_select #(.SYS_REF_MHZ(REF_MHZ)) dut (.sys_clk(sys_clk),
      .rst(rst), .platform_ratio_strap(plat_s),
      .local_bus_control_strap(lbc_s), .address_latch_strap(ale_s),
      .general_purpose_line_two_strap(gpl_s), .memory_ratio_strap(mem_s),
      .io_port_config_strap(io_s), .pci_async_strap(pci_s),
      .memory_clock_divide_setting(div_set), .memory_init_start(init_go),
      .platform_ratio_r(plat_o), .core_ratio_halves_r(core_o),
      .mem_pll_ratio_r(mpll_o), .mem_sync_mode_r(sync_o),
      .mem_data_from_pll_r(pll_o), .mem_bus_div_r(div_o),
      .pci_clk_from_alt_r(alt_o), .lane1_power_down_r(pd_o),
      .config_error_r(err_o), .ratios_valid_r(val_o));

   // clock and hang guard
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // platform multiplier expected for a strap code
   function automatic logic [3:0] e_plat(input logic [3:0] c);
      return (c inside {3, 4, 5, 6, 8, 9, 10, 12}) ? c : 4'h0;
   endfunction

   task automatic chk(input string nm, input logic [3:0] e,
                      input logic [3:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask

   // compare every decoded output against the straps in v
   task automatic check_all(input logic [13:0] v);
      logic bad;
      bad = e_plat(v[13:10]) == 4'h0 || v[9:7] == 3'h2 || v[6:4] == 3'h6 ||
            (!v[0] && (REF_MHZ < 33 || REF_MHZ > 66));
      chk("platform", e_plat(v[13:10]), plat_o);
      chk("core", ct[v[9:7]], core_o);
      chk("mem pll", mt[v[6:4]], mpll_o);
      chk("sync", 4'(v[6:4] == 3'h7), 4'(sync_o));
      chk("data src", 4'(v[6:4] != 3'h7), 4'(pll_o));
      chk("bus div", div_set ? 4'h4 : 4'h2, 4'(div_o));
      chk("pci alt", 4'(v[0]), 4'(alt_o));
      chk("lane pd", 4'(v[3:1] == 3'h7), 4'(pd_o));
      chk("cfg err", 4'(bad), 4'(err_o));
      chk("valid", 4'h1, 4'(val_o));
   endtask

   // one reset, capture, check, then strap change that must be ignored
   task automatic run_one(input int id, input logic [13:0] v);
      rst = 1'b1;
      cfg = v;
      tick(2);
      chk("valid in reset", 4'h0, 4'(val_o));
      rst = 1'b0;
      tick(2);
      check_all(v);
      cfg = ~v;
      tick(2);
      check_all(v);
      $display("test %0d done", id);
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // corner codes of every field, random straps, then divide and lock
   initial begin
      void'($urandom(5));
      tick(10);
      for (int i = 0; i < 16; i++) begin
         run_one(i, {4'(i), 3'(i), ~3'(i), 3'(i), i[0]});
      end
      for (int i = 16; i < 56; i++) begin
         div_set = 1'($urandom);
         run_one(i, 14'($urandom));
      end
      div_set = 1'b1;
      tick(1);
      chk("bus div", 4'h4, 4'(div_o));
      div_set = 1'b0; // setting still followed while init has not started
      tick(1);
      chk("bus div", 4'h2, 4'(div_o));
      div_set = 1'b1;
      init_go = 1'b1;
      tick(1);
      init_go = 1'b0;
      div_set = 1'b0;
      tick(3);
      chk("bus div locked", 4'h4, 4'(div_o));
      $display("test divide done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
